// *** urbpm_cfg.svh ***
// Constants for the serial receiver, baud generator and transmitter
`ifndef URBPM_CFG_SVH
`define URBPM_CFG_SVH
`define URBPM_OVERSAMPLE 5'h10
`define URBPM_SMP_A 5'h08
`define URBPM_SMP_B 5'h09
`define URBPM_SMP_C 5'h0A
`define URBPM_EDGE_A 5'h03
`define URBPM_EDGE_B 5'h05
`define URBPM_EDGE_C 5'h07
`define URBPM_PR_0 20'h0_0001
`define URBPM_PR_1 20'h0_0003
`define URBPM_PR_2 20'h0_0004
`define URBPM_PR_3 20'h0_000D
`define URBPM_BITS_8 4'h8
`define URBPM_BITS_9 4'h9
`define URBPM_FRAME_10 4'hA
`define URBPM_FRAME_11 4'hB
`define URBPM_IDLE_TICKS_10 8'hA0
`define URBPM_IDLE_TICKS_11 8'hB0
`define URBPM_FIFO_DEPTH 32
`define URBPM_HIST_RST 3'h7
`define URBPM_TXD_RST 1'b1
`define URBPM_ARM_RST 1'b1
`endif

// *** urbpm_pkg.sv ***
// Types shared by the serial block
package urbpm_pkg;
  typedef enum logic [1:0] {
    RX_HUNT = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b11,
    RX_STOP = 2'b10
  } urbpm_rx_e;
  typedef struct packed {
    logic [1:0] prescaleSel;
    logic [2:0] txRateSel;
    logic [2:0] rxRateSel;
    logic [7:0] txFine;
    logic [7:0] rxFine;
  } urbpm_baud_s;
  typedef struct packed {
    logic wordLen9;
    logic parityEnable;
    logic parityOdd;
    logic wakeAddr;
    logic parityIrqEnable;
  } urbpm_frame_s;
  typedef struct packed {
    logic rxFull;
    logic idle;
    logic overrun;
    logic noise;
    logic framing;
    logic parity;
  } urbpm_status_s;
endpackage

// *** urbpm_top.sv ***
// Serial receiver with baud generation, parity, mute and transmit path
// Operation
// - Stop bit missing or break received sets framing error flag
// - Framing error still transfers word; flag rises with receive-full, no own interrupt
// - Error flags clear only by status read followed by data read
// - Each direction: clock over 16, coarse prescale and own rate divider
// - Prescale picks 1, 3, 4 or 13; rate selects power of two 1..128
// - Eight-bit fine divider per direction; zero leaves it inactive
// - Mute request puts receiver asleep: no receive flags, no receive interrupts
// - Muted receiver wakes on idle line or address mark per wake bit
// - Idle wake clears mute request and leaves idle flag unset
// - Address mark wake clears mute, sets receive-full, keeps word
// - Length and parity bits choose 8, 7+P, 9 or 8+P data bits
// - Address mark uses the last received bit, which is the parity bit when parity is on
// - Parity makes ones count even or odd per parity select
// - Transmitter sends parity in place of data MSB
// - Receiver sets parity error on mismatch; interrupt if enabled
// - Sixteen samples per bit; majority of samples 8, 9, 10 is value
// - Data bit noise when samples 8, 9, 10 differ
// - Sampling restarts at every start bit
// - Start noise unless three ones before edge and samples 3, 5, 7 low
// - Start noise if any of samples 8, 9, 10 is one
// - Receive-full set when word moves into data buffer
`timescale 1ns/1ps
`include "urbpm_cfg.svh"

module urbpm_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = `URBPM_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_reg;
  logic [AW-1:0] rdPtr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;
  assign push = inValid & inReady;
  assign pop = outValid & outReady;
  assign outData = mem[rdPtr_reg];
  assign outValid = (count_reg != '0);
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wrPtr_reg] <= inData;
    end
  end
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
      inReady <= 1'b0;
    end else begin
      if (push) begin
        wrPtr_reg <= wrPtr_reg + 1'b1;
      end
      if (pop) begin
        rdPtr_reg <= rdPtr_reg + 1'b1;
      end
      count_reg <= count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      inReady <= (count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop}) != (AW+1)'(DEPTH);
    end
  end
endmodule

module urbpm_top #(
  parameter int DIV_W = 20
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Serial pins
  input wire logic rxd,
  output logic txd,
  // Configuration
  input wire urbpm_pkg::urbpm_baud_s baudCfg,
  input wire urbpm_pkg::urbpm_frame_s frameCfg,
  input wire logic rxEnable,
  input wire logic txEnable,
  // Mute control
  input wire logic muteWrite,
  input wire logic muteWriteValue,
  output logic muteRequest,
  // Receive status and data
  input wire logic statusRead,
  input wire logic dataRead,
  output urbpm_pkg::urbpm_status_s status,
  output logic [8:0] rxData,
  output logic parityIrq,
  // Transmit data
  input wire logic txValid,
  output logic txReady,
  input wire logic [8:0] txWord,
  output logic txBusy
);
  import urbpm_pkg::*;

  function automatic logic [DIV_W-1:0] divisor(input logic [1:0] ps, input logic [2:0] rs, input logic [7:0] fine);
    logic [DIV_W-1:0] base;
    base = '0;
    unique case (ps)
      2'h0: base = DIV_W'(`URBPM_PR_0);
      2'h1: base = DIV_W'(`URBPM_PR_1);
      2'h2: base = DIV_W'(`URBPM_PR_2);
      2'h3: base = DIV_W'(`URBPM_PR_3);
    endcase
    base = base << rs;
    if (fine != 8'h00) begin
      base = DIV_W'(base * {{(DIV_W-8){1'b0}}, fine});
    end
    return base;
  endfunction

  function automatic logic majority(input logic [2:0] s);
    return (s[0] & s[1]) | (s[1] & s[2]) | (s[0] & s[2]);
  endfunction

  // Baud dividers
  logic [DIV_W-1:0] rxDiv;
  logic [DIV_W-1:0] txDiv;
  logic [DIV_W-1:0] rxCnt_reg;
  logic [DIV_W-1:0] txCnt_reg;
  logic rxTick_reg;
  logic txTick_reg;
  assign rxDiv = divisor(baudCfg.prescaleSel, baudCfg.rxRateSel, baudCfg.rxFine);
  assign txDiv = divisor(baudCfg.prescaleSel, baudCfg.txRateSel, baudCfg.txFine);

  always_ff @(posedge mclk) begin
    if (!reset_n || !rxEnable) begin
      rxCnt_reg <= '0;
      rxTick_reg <= 1'b0;
    end else begin
      rxTick_reg <= (rxCnt_reg == rxDiv - 1'b1);
      rxCnt_reg <= (rxCnt_reg == rxDiv - 1'b1) ? '0 : rxCnt_reg + 1'b1;
    end
  end
  always_ff @(posedge mclk) begin
    if (!reset_n || !txEnable) begin
      txCnt_reg <= '0;
      txTick_reg <= 1'b0;
    end else begin
      txTick_reg <= (txCnt_reg == txDiv - 1'b1);
      txCnt_reg <= (txCnt_reg == txDiv - 1'b1) ? '0 : txCnt_reg + 1'b1;
    end
  end

  // Receiver sampling
  urbpm_rx_e rxState_reg;
  logic [4:0] smpIdx_reg;
  logic [3:0] bitIdx_reg;
  logic [2:0] hist_reg;
  logic [2:0] smp_reg;
  logic edgeOk_reg;
  logic startLate_reg;
  logic noiseAcc_reg;
  logic stopBad_reg;
  logic [8:0] rxShift_reg;
  logic frameDone_reg;
  logic [7:0] idleCnt_reg;
  logic [3:0] dataBits;
  logic [7:0] idleTicks;
  logic bitEnd;
  logic smpSame;
  assign dataBits = frameCfg.wordLen9 ? `URBPM_BITS_9 : `URBPM_BITS_8;
  assign idleTicks = frameCfg.wordLen9 ? `URBPM_IDLE_TICKS_11 : `URBPM_IDLE_TICKS_10;
  assign bitEnd = rxTick_reg && (rxState_reg != RX_HUNT) && (smpIdx_reg == `URBPM_OVERSAMPLE);
  assign smpSame = (smp_reg == 3'h0) || (smp_reg == 3'h7);

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      hist_reg <= `URBPM_HIST_RST;
    end else if (rxTick_reg) begin
      hist_reg <= {hist_reg[1:0], rxd};
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n || !rxEnable) begin
      rxState_reg <= RX_HUNT;
      smpIdx_reg <= 5'h00;
      bitIdx_reg <= 4'h0;
      smp_reg <= 3'h0;
      edgeOk_reg <= 1'b0;
      startLate_reg <= 1'b0;
      stopBad_reg <= 1'b0;
      rxShift_reg <= 9'h000;
      frameDone_reg <= 1'b0;
    end else begin
      frameDone_reg <= 1'b0;
      if (rxTick_reg) begin
        smpIdx_reg <= smpIdx_reg + 5'h01;
        if (smpIdx_reg == `URBPM_SMP_A) begin
          smp_reg[0] <= rxd;
        end
        if (smpIdx_reg == `URBPM_SMP_B) begin
          smp_reg[1] <= rxd;
        end
        if (smpIdx_reg == `URBPM_SMP_C) begin
          smp_reg[2] <= rxd;
        end
        unique case (rxState_reg)
          RX_HUNT: begin
            if (!rxd) begin
              rxState_reg <= RX_START;
              smpIdx_reg <= 5'h02;
              edgeOk_reg <= (hist_reg == 3'h7);
              startLate_reg <= 1'b0;
            end
          end
          RX_START: begin
            if (rxd && (smpIdx_reg == `URBPM_EDGE_A || smpIdx_reg == `URBPM_EDGE_B || smpIdx_reg == `URBPM_EDGE_C)) begin
              startLate_reg <= 1'b1;
            end
            if (bitEnd) begin
              smpIdx_reg <= 5'h01;
              bitIdx_reg <= 4'h0;
              rxState_reg <= majority(smp_reg) ? RX_HUNT : RX_DATA;
            end
          end
          RX_DATA: begin
            if (bitEnd) begin
              smpIdx_reg <= 5'h01;
              rxShift_reg <= {majority(smp_reg), rxShift_reg[8:1]};
              bitIdx_reg <= bitIdx_reg + 4'h1;
              if (bitIdx_reg == dataBits - 4'h1) begin
                rxState_reg <= RX_STOP;
              end
            end
          end
          RX_STOP: begin
            if (bitEnd) begin
              stopBad_reg <= !majority(smp_reg);
              frameDone_reg <= 1'b1;
              rxState_reg <= RX_HUNT;
            end
          end
        endcase
      end
    end
  end

  // Noise accumulates over a frame, false starts included
  logic clearNow;
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      noiseAcc_reg <= 1'b0;
    end else if (bitEnd && rxState_reg == RX_START) begin
      noiseAcc_reg <= noiseAcc_reg | !edgeOk_reg | startLate_reg | (smp_reg != 3'h0);
    end else if (bitEnd && rxState_reg == RX_DATA) begin
      noiseAcc_reg <= noiseAcc_reg | !smpSame;
    end else if (frameDone_reg) begin
      noiseAcc_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n || !rxEnable || rxState_reg != RX_HUNT || !rxd) begin
      idleCnt_reg <= 8'h00;
    end else if (rxTick_reg && idleCnt_reg != idleTicks) begin
      idleCnt_reg <= idleCnt_reg + 8'h01;
    end
  end

  // Frame completion
  logic [8:0] wordAligned;
  logic addrMark;
  logic parityBad;
  logic idleHit;
  logic accept;
  logic fullEff;
  logic transfer;
  logic overrunSet;
  logic idleSet;
  logic idleArmed_reg;
  logic statusSeen_reg;
  logic peNext;
  assign wordAligned = frameCfg.wordLen9 ? rxShift_reg : {1'b0, rxShift_reg[8:1]};
  assign addrMark = rxShift_reg[8];
  // parity over data and parity bit
  assign parityBad = frameCfg.parityEnable && ((^wordAligned) != frameCfg.parityOdd);
  assign idleHit = rxTick_reg && rxd && rxState_reg == RX_HUNT && idleCnt_reg == idleTicks - 8'h01;
  // muted frames dropped unless address mark with address wake selected
  assign accept = frameDone_reg && (!muteRequest || (frameCfg.wakeAddr && addrMark));
  assign clearNow = dataRead && statusSeen_reg;
  assign fullEff = status.rxFull && !clearNow;
  assign transfer = accept && !fullEff;
  assign overrunSet = accept && fullEff;
  assign idleSet = idleHit && !muteRequest && idleArmed_reg;
  assign peNext = (transfer && parityBad) ? 1'b1 : (clearNow ? 1'b0 : status.parity);

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      statusSeen_reg <= 1'b0;
    end else if (statusRead) begin
      statusSeen_reg <= 1'b1;
    end else if (dataRead) begin
      statusSeen_reg <= 1'b0;
    end
  end

  // flags set with transfer, overrun on a blocked frame and idle on idle line; all cleared by read sequence
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      status <= '0;
      rxData <= 9'h000;
      parityIrq <= 1'b0;
    end else begin
      if (transfer) begin
        rxData <= wordAligned;
      end
      status.rxFull <= transfer ? 1'b1 : (clearNow ? 1'b0 : status.rxFull);
      status.framing <= (transfer && stopBad_reg) ? 1'b1 : (clearNow ? 1'b0 : status.framing);
      status.noise <= (transfer && noiseAcc_reg) ? 1'b1 : (clearNow ? 1'b0 : status.noise);
      status.overrun <= overrunSet ? 1'b1 : (clearNow ? 1'b0 : status.overrun);
      status.idle <= idleSet ? 1'b1 : (clearNow ? 1'b0 : status.idle);
      status.parity <= peNext;
      parityIrq <= peNext && frameCfg.parityIrqEnable;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      idleArmed_reg <= `URBPM_ARM_RST;
    end else if (transfer) begin
      idleArmed_reg <= 1'b1;
    end else if (idleSet) begin
      idleArmed_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      muteRequest <= 1'b0;
    end else if (muteWrite) begin
      muteRequest <= muteWriteValue;
    end else if (muteRequest && ((idleHit && !frameCfg.wakeAddr) || (accept && frameCfg.wakeAddr))) begin
      muteRequest <= 1'b0;
    end
  end

  // Transmitter
  logic fifoValid;
  logic fifoTake;
  logic [8:0] fifoWord;
  logic [10:0] txFrame_reg;
  logic [3:0] txLeft_reg;
  logic [3:0] txSub_reg;
  logic idlePending_reg;
  logic txEnPrev_reg;
  logic [8:0] txData;
  // Idle frame goes out before the first word after enable
  assign fifoTake = fifoValid && txEnable && txEnPrev_reg && !txBusy && !idlePending_reg;

  urbpm_fifo #(.WIDTH(9), .DEPTH(`URBPM_FIFO_DEPTH)) txFifo (
    .mclk(mclk),
    .reset_n(reset_n),
    .inValid(txValid),
    .inReady(txReady),
    .inData(txWord),
    .outValid(fifoValid),
    .outReady(fifoTake),
    .outData(fifoWord)
  );

  always_comb begin
    txData = fifoWord;
    if (frameCfg.parityEnable && frameCfg.wordLen9) begin
      txData[8] = (^fifoWord[7:0]) ^ frameCfg.parityOdd;
    end else if (frameCfg.parityEnable) begin
      txData[7] = (^fifoWord[6:0]) ^ frameCfg.parityOdd;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      txEnPrev_reg <= 1'b0;
      idlePending_reg <= 1'b0;
    end else begin
      txEnPrev_reg <= txEnable;
      if (txEnable && !txEnPrev_reg) begin
        idlePending_reg <= 1'b1;
      end else if (!txBusy) begin
        idlePending_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n || !txEnable) begin
      txFrame_reg <= 11'h7FF;
      txLeft_reg <= 4'h0;
      txSub_reg <= 4'h0;
      txBusy <= 1'b0;
      txd <= `URBPM_TXD_RST;
    end else if (!txBusy && idlePending_reg) begin
      txFrame_reg <= 11'h7FF;
      txLeft_reg <= frameCfg.wordLen9 ? `URBPM_FRAME_11 : `URBPM_FRAME_10;
      txSub_reg <= 4'h0;
      txBusy <= 1'b1;
    end else if (fifoTake) begin
      txFrame_reg <= frameCfg.wordLen9 ? {1'b1, txData, 1'b0} : {2'b11, txData[7:0], 1'b0};
      txLeft_reg <= frameCfg.wordLen9 ? `URBPM_FRAME_11 : `URBPM_FRAME_10;
      txSub_reg <= 4'h0;
      txBusy <= 1'b1;
    end else if (txBusy && txTick_reg) begin
      txd <= txFrame_reg[0];
      txSub_reg <= txSub_reg + 4'h1;
      if (txSub_reg == 4'hF) begin
        txFrame_reg <= {1'b1, txFrame_reg[10:1]};
        txLeft_reg <= txLeft_reg - 4'h1;
        if (txLeft_reg == 4'h1) begin
          txBusy <= 1'b0;
          txd <= 1'b1;
        end
      end
    end
  end

  a_fe_with_full: assert property (@(posedge mclk) disable iff (!reset_n) $rose(status.framing) |-> status.rxFull)
    else $error("framing flag rose without receive-full");
  a_fe_clear_seq: assert property (@(posedge mclk) disable iff (!reset_n) $fell(status.framing) |-> $past(dataRead) && $past(statusSeen_reg))
    else $error("framing flag cleared without read sequence");
  a_mute_no_flags: assert property (@(posedge mclk) disable iff (!reset_n) $rose(status.rxFull) && !$past(muteWrite) |-> !muteRequest)
    else $error("receive-full set while muted");
  a_idle_wake_quiet: assert property (@(posedge mclk) disable iff (!reset_n) $fell(muteRequest) && !frameCfg.wakeAddr |-> !$rose(status.idle))
    else $error("idle flag set on idle wake");
  a_addr_wake_full: assert property (@(posedge mclk) disable iff (!reset_n) $fell(muteRequest) && !$past(muteWrite) && frameCfg.wakeAddr |-> $past(frameDone_reg) && $past(addrMark))
    else $error("address wake without address word");
  a_parity_cause: assert property (@(posedge mclk) disable iff (!reset_n) $rose(status.parity) |-> $past(frameCfg.parityEnable) && $past(transfer))
    else $error("parity error without checked transfer");
  a_rx_tick_div: assert property (@(posedge mclk) disable iff (!reset_n || !rxEnable) rxTick_reg && $past(rxEnable, 2) |-> $past(rxCnt_reg) == rxDiv - 1'b1)
    else $error("receive tick off divisor");
  a_start_resync: assert property (@(posedge mclk) disable iff (!reset_n || !rxEnable) rxTick_reg && rxState_reg == RX_HUNT && !rxd |=> rxState_reg == RX_START && smpIdx_reg == 5'h02)
    else $error("start edge did not restart sampling");
  a_data_majority: assert property (@(posedge mclk) disable iff (!reset_n || !rxEnable) bitEnd && rxState_reg == RX_DATA |=> rxShift_reg[8] == majority($past(smp_reg)))
    else $error("data bit not majority of samples");
  a_data_noise: assert property (@(posedge mclk) disable iff (!reset_n) bitEnd && rxState_reg == RX_DATA && !smpSame |=> noiseAcc_reg)
    else $error("uneven samples did not mark noise");
endmodule

// *** urbpm_peer.sv ***
// Far-side serial model: frame sender on rxd and frame capturer on txd
`timescale 1ns/1ps
module urbpm_peer (
  // Clock
  input wire logic mclk,
  // Serial lines
  output logic rxd,
  input wire logic txd
);
  initial rxd = 1'b1;

  task automatic send(input logic [8:0] w, input int n, input logic stp, input int gb, input int gs, input int gl,
                      input int per);
    logic [10:0] f;
    int b;
    int c;
    f = 11'h7FF;
    f[0] = 1'b0;
    for (b = 0; b < n; b++) f[b + 1] = w[b];
    f[n + 1] = stp;
    for (b = 0; b <= n + 1; b++) begin
      for (c = 0; c < per; c++) begin
        @(negedge mclk);
        rxd = f[b] ^ (b == gb && c >= gs - 1 && c < gs - 1 + gl);
      end
    end
    @(negedge mclk);
    rxd = 1'b1;
  endtask

  task automatic capture(input int per, input int n, output logic [8:0] w, output int lowLen);
    int c;
    int t;
    t = 0;
    w = 9'h000;
    lowLen = 0;
    while (txd !== 1'b0 && t < 20000) begin
      @(negedge mclk);
      t++;
    end
    for (c = 0; c < per * (n + 1); c++) begin
      if (lowLen == 0 && txd === 1'b1) lowLen = c;
      if (c % per == per / 2 && c >= per) w[c / per - 1] = txd;
      @(negedge mclk);
    end
  endtask
endmodule

// *** urbpm_top_bench.sv ***
// Self-checking bench for the serial block
`timescale 1ns/1ps
module urbpm_top_bench;
  import urbpm_pkg::*;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic rxd;
  logic txd;
  urbpm_baud_s baudCfg = '0;
  urbpm_frame_s frameCfg = '0;
  logic rxEnable = 1'b1;
  logic txEnable = 1'b0;
  logic muteWrite = 1'b0;
  logic muteWriteValue = 1'b0;
  logic muteRequest;
  logic statusRead = 1'b0;
  logic dataRead = 1'b0;
  urbpm_status_s status;
  logic [8:0] rxData;
  logic parityIrq;
  logic txValid = 1'b0;
  logic txReady;
  logic [8:0] txWord = 9'h000;
  logic txBusy;
  int errors = 0;
  int compares = 0;

  always #5 mclk = ~mclk;

  urbpm_top urbpm_top_i (.mclk(mclk), .reset_n(reset_n), .rxd(rxd), .txd(txd), .baudCfg(baudCfg),
    .frameCfg(frameCfg), .rxEnable(rxEnable), .txEnable(txEnable), .muteWrite(muteWrite),
    .muteWriteValue(muteWriteValue), .muteRequest(muteRequest), .statusRead(statusRead), .dataRead(dataRead),
    .status(status), .rxData(rxData), .parityIrq(parityIrq), .txValid(txValid), .txReady(txReady),
    .txWord(txWord), .txBusy(txBusy));
  urbpm_peer urbpm_peer_i (.mclk(mclk), .rxd(rxd), .txd(txd));

  task automatic stop_test();
    if (errors == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check1(input string what, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic checkN(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic rdPulse(input logic s, input logic d);
    @(negedge mclk);
    statusRead = s;
    dataRead = d;
    @(negedge mclk);
    statusRead = 1'b0;
    dataRead = 1'b0;
  endtask

  task automatic clearFlags();
    rdPulse(1'b1, 1'b0);
    rdPulse(1'b0, 1'b1);
  endtask

  task automatic mute(input logic v);
    @(negedge mclk);
    muteWrite = 1'b1;
    muteWriteValue = v;
    @(negedge mclk);
    muteWrite = 1'b0;
  endtask

  task automatic rx(input logic [8:0] w, input int n, input logic stp, input int gb, input int gs, input int gl);
    urbpm_peer_i.send(w, n, stp, gb, gs, gl, 16);
    cyc(4);
  endtask

  task automatic push(input logic [8:0] w);
    int n;
    n = 0;
    @(negedge mclk);
    txValid = 1'b1;
    txWord = w;
    while (txReady !== 1'b1 && n < 100) begin
      @(negedge mclk);
      n++;
    end
    @(negedge mclk);
    txValid = 1'b0;
  endtask

  task automatic t_reset();
    checkN("status", 0, status);
    checkN("rxData", 0, rxData);
    check1("txd", 1'b1, txd);
    check1("txBusy", 1'b0, txBusy);
    check1("muteRequest", 1'b0, muteRequest);
    check1("txReady", 1'b1, txReady);
  endtask

  task automatic t_modes();
    logic [8:0] w;
    logic bad;
    int n;
    for (int i = 0; i < 8; i++) begin
      frameCfg = '{wordLen9: i[0], parityEnable: i[1], parityOdd: i[2], wakeAddr: 1'b0, parityIrqEnable: 1'b1};
      bad = i[2] ^ i[0];
      n = i[0] ? 9 : 8;
      w = i[0] ? 9'h0B5 ^ i : 9'h035 ^ i;
      w[n - 1] = i[1] ? ((i[0] ? ^w[7:0] : ^w[6:0]) ^ i[2] ^ bad) : i[2];
      clearFlags();
      rx(w, n, 1'b1, -1, 0, 0);
      check1("rxFull", 1'b1, status.rxFull);
      checkN("rxData", w, rxData);
      check1("parity", i[1] & bad, status.parity);
      check1("parityIrq", i[1] & bad, parityIrq);
    end
    frameCfg = '0;
  endtask

  task automatic t_framing();
    for (int k = 0; k < 2; k++) begin
      clearFlags();
      rx(k ? 9'h05A : 9'h000, 8, 1'b0, -1, 0, 0);
      check1("framing", 1'b1, status.framing);
      check1("rxFull", 1'b1, status.rxFull);
      checkN("rxData", k ? 9'h05A : 9'h000, rxData);
    end
    rdPulse(1'b0, 1'b1);
    check1("framing", 1'b1, status.framing);
    rdPulse(1'b1, 1'b0);
    check1("framing", 1'b1, status.framing);
    rdPulse(1'b0, 1'b1);
    check1("framing", 1'b0, status.framing);
  endtask

  task automatic t_overrun();
    clearFlags();
    rx(9'h0A1, 8, 1'b1, -1, 0, 0);
    rx(9'h03C, 8, 1'b0, -1, 0, 0);
    check1("overrun", 1'b1, status.overrun);
    check1("framing", 1'b0, status.framing);
    checkN("rxData", 9'h0A1, rxData);
    clearFlags();
    check1("rxFull", 1'b0, status.rxFull);
  endtask

  task automatic t_noise();
    int tb[5][4] = '{'{3, 9, 1, 1}, '{3, 8, 2, 1}, '{3, 3, 1, 0}, '{0, 5, 1, 1}, '{0, 9, 1, 1}};
    for (int i = 0; i < 5; i++) begin
      clearFlags();
      rx(9'h0C3, 8, 1'b1, tb[i][0], tb[i][1], tb[i][2]);
      check1("noise", tb[i][3], status.noise);
      checkN("rxData", tb[i][2] == 2 ? 9'h0C7 : 9'h0C3, rxData);
    end
  endtask

  task automatic t_mute();
    for (int k = 0; k < 2; k++) begin
      frameCfg = '{wordLen9: k[0], parityEnable: 1'b0, parityOdd: 1'b0, wakeAddr: 1'b1, parityIrqEnable: 1'b0};
      clearFlags();
      mute(1'b1);
      check1("muteRequest", 1'b1, muteRequest);
      rx(k ? 9'h0A5 : 9'h05A, k ? 9 : 8, 1'b0, -1, 0, 0);
      check1("rxFull", 1'b0, status.rxFull);
      check1("framing", 1'b0, status.framing);
      rx(k ? 9'h1A5 : 9'h0A5, k ? 9 : 8, 1'b1, -1, 0, 0);
      check1("muteRequest", 1'b0, muteRequest);
      check1("rxFull", 1'b1, status.rxFull);
      checkN("rxData", k ? 9'h1A5 : 9'h0A5, rxData);
    end
    frameCfg = '0;
  endtask

  task automatic t_idleWake();
    cyc(200);
    clearFlags();
    mute(1'b1);
    rx(9'h0A5, 8, 1'b1, -1, 0, 0);
    check1("muteRequest", 1'b1, muteRequest);
    cyc(200);
    check1("muteRequest", 1'b0, muteRequest);
    check1("idle", 1'b0, status.idle);
    check1("rxFull", 1'b0, status.rxFull);
  endtask

  task automatic t_fifo();
    logic [8:0] got;
    int len;
    for (int k = 0; k < 32; k++) push(9'h040 + k);
    cyc(2);
    check1("txReady", 1'b0, txReady);
    txEnable = 1'b1;
    cyc(100);
    check1("txdIdle", 1'b1, txd);
    check1("txBusyIdle", 1'b1, txBusy);
    urbpm_peer_i.capture(16, 8, got, len);
    checkN("txWord", 9'h040, got);
    cyc(6000);
    check1("txBusy", 1'b0, txBusy);
    check1("txReady", 1'b1, txReady);
  endtask

  task automatic t_baud();
    int pr[4] = '{1, 3, 4, 13};
    int tb[5][4] = '{'{0, 0, 0, 0}, '{1, 1, 0, 1}, '{3, 0, 0, 0}, '{2, 0, 3, 0}, '{0, 2, 2, 1}};
    int per;
    int len;
    logic [8:0] got;
    for (int i = 0; i < 5; i++) begin
      per = 16 * pr[tb[i][0]] * (1 << tb[i][1]) * (tb[i][2] == 0 ? 1 : tb[i][2]);
      @(negedge mclk);
      txEnable = 1'b0;
      rxEnable = 1'b0;
      baudCfg = '{prescaleSel: tb[i][0], txRateSel: tb[i][1], rxRateSel: tb[i][1], txFine: tb[i][2],
                  rxFine: tb[i][2]};
      frameCfg.parityEnable = tb[i][3];
      cyc(2);
      txEnable = 1'b1;
      rxEnable = 1'b1;
      push(9'h043);
      urbpm_peer_i.capture(per, 8, got, len);
      checkN("startLen", per, len);
      checkN("txWord", tb[i][3] ? 9'h0C3 : 9'h043, got);
      cyc(per * 2);
      clearFlags();
      urbpm_peer_i.send(9'h03C, 8, 1'b1, -1, 0, 0, per);
      cyc(4);
      checkN("rxData", 9'h03C, rxData);
    end
  endtask

  initial begin
    #800_000;
    errors++;
    stop_test();
  end

  initial begin
    cyc(10);
    reset_n = 1'b1;
    @(negedge mclk);
    t_reset();
    cyc(2);
    t_modes();
    t_framing();
    t_overrun();
    t_noise();
    t_mute();
    t_idleWake();
    t_fifo();
    t_baud();
    stop_test();
  end
endmodule
